/* File: prog_loader_defines.svh */
// Constants for the programming word loader
// Function
// - Sixteen-bit write-only programming port loads gains, levels, offsets, tones and codes.
// - Serial-bus or power-up reset restores every programmed value to default.
// - Every write to the port clears the programming-ready flag.
// - Ready flag returns to one when the word's action completes, within 250 us.
// - Words within a block arrive in order; blocks in any order.
// - A block may end early; later words keep their values.
// - Bit 15 marks the first word of a block.
// - With bit 14 set, bits 13:12 pick block 0, 1 or 2; 12-bit data.
// - With bit 14 clear, word goes to block 3 with 14-bit data.
// - Modem block: eight byte words, frame sync, two seeds, bit sync.
// - Tone block: six words, level and emphasis, detect settings, four tones.
// - Sub-audio block: five words, level, detect, code halves, dropout time.
// - Digital code split: bits 11:0 first word, upper bits next.
// - Frame sync defaults to cb23; its top bit meets the earliest bit.
// - An all-zero scramble seed means no scrambling is applied.
`ifndef PROG_LOADER_DEFINES_SVH
`define PROG_LOADER_DEFINES_SVH

`define PROG_PORT_OFFSET     8'hc8
`define STATUS_OFFSET        8'hc6
`define STATUS_READY_BIT     0
`define FIRST_WORD_BIT       15
`define BLOCK_KIND_BIT       14
`define BLOCK_SEL_HI         13
`define BLOCK_SEL_LO         12
`define MODEM_WORDS          8
`define TONE_WORDS           6
`define SUB_WORDS            5
`define GAIN_WORDS           9
`define FRAME_SYNC_RESET     16'hcb23
`define BIT_SYNC_RESET       16'h5555
`define SEED_RESET           16'h0000
`define WORD12_RESET         12'h000
`define WORD14_RESET         14'h0000
`define PROG_ACTION_US       250
`define CLK_FREQ_MHZ         40

`endif

/* File: prog_loader_pkg.sv */
// Types shared by the programming word loader modules
`default_nettype none
package prog_loader_pkg;
  typedef enum logic [1:0] {
    BLK_MODEM = 2'h0,
    BLK_TONE  = 2'h1,
    BLK_SUB   = 2'h2,
    BLK_GAIN  = 2'h3
  } block_t;

  typedef enum logic [1:0] {
    ST_READY = 2'h1,
    ST_BUSY  = 2'h2
  } prog_state_t;
endpackage
`default_nettype wire

/* File: prog_word_if.sv */
// Decoded programming word passed from the decoder to the loader
`default_nettype none
interface prog_word_if;
  import prog_loader_pkg::*;
  logic         valid;
  block_t       blk;
  logic [3:0]   idx;
  logic [13:0]  data;
  modport src (output valid, output blk, output idx, output data);
  modport dst (input valid, input blk, input idx, input data);
endinterface
`default_nettype wire

/* File: prog_word_decoder.sv */
// Decodes block, start marker and word index of each programming word
`include "prog_loader_defines.svh"
`default_nettype none
module prog_word_decoder
  import prog_loader_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        busRst,
  input  wire logic        wrStrobe,
  input  wire logic [15:0] wrWord,
  prog_word_if.src         word
);
  logic [3:0] idx_ff [4];
  logic       reserved;
  block_t     blkSel;
  logic [3:0] nxt_idx;

  // Block code from the high bits; 111 is refused
  always_comb begin
    reserved = 1'b0;
    if (wrWord[`BLOCK_KIND_BIT]) begin
      blkSel   = block_t'(wrWord[`BLOCK_SEL_HI:`BLOCK_SEL_LO]);
      reserved = (wrWord[`BLOCK_SEL_HI:`BLOCK_SEL_LO] == 2'h3);
    end else begin
      blkSel = BLK_GAIN;
    end
    nxt_idx = wrWord[`FIRST_WORD_BIT] ? 4'h0 : idx_ff[blkSel] + 4'h1;
  end

  // Per-block index; blocks may interleave so each keeps its own count
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 4; i++) idx_ff[i] <= 4'h0;
    end else if (busRst) begin
      for (int i = 0; i < 4; i++) idx_ff[i] <= 4'h0;
    end else if (wrStrobe && !reserved) begin
      idx_ff[blkSel] <= nxt_idx;
    end
  end

  // Registered hand-off to the loader
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      word.valid <= 1'b0;
      word.blk   <= BLK_MODEM;
      word.idx   <= 4'h0;
      word.data  <= 14'h0000;
    end else begin
      word.valid <= wrStrobe && !reserved && !busRst;
      word.blk   <= blkSel;
      word.idx   <= nxt_idx;
      word.data  <= wrWord[13:0];
    end
  end
endmodule
`default_nettype wire

/* File: programming_word_loader.sv */
// Programming word port: paces writes and holds the loaded setting blocks
`include "prog_loader_defines.svh"
`default_nettype none
module programming_word_loader
  import prog_loader_pkg::*;
#(
  parameter int BUSY_CYCLES = `PROG_ACTION_US * `CLK_FREQ_MHZ
)(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        busRst,
  input  wire logic        regWrEn,
  input  wire logic        regRdEn,
  input  wire logic [7:0]  regAddr,
  input  wire logic [15:0] regWrData,
  output logic      [15:0] regRdData,
  output logic             progReady,
  output logic      [15:0] frameSync,
  output logic      [15:0] scrambleSeed1,
  output logic      [15:0] scrambleSeed2,
  output logic             seed1Bypass,
  output logic             seed2Bypass,
  output logic      [15:0] bitSync,
  output logic      [10:0] toneTxLevel,
  output logic             deemphEn,
  output logic      [1:0]  toneLength,
  output logic      [5:0]  detectThreshold,
  output logic      [3:0]  detectBandwidth,
  output logic      [43:0] progTones,
  output logic      [11:0] subTxLevel,
  output logic             long_digital_code_select,
  output logic      [9:0]  subDetect,
  output logic      [23:0] digitalCode,
  output logic      [3:0]  dropoutTime,
  output logic      [125:0] gainWords
);
  localparam int CW = $clog2(BUSY_CYCLES + 1);

  prog_word_if word ();

  logic        wrStrobe;
  prog_state_t state_ff;
  logic [CW-1:0] busyCnt_ff;
  logic [15:0] rdData_ff;
  logic [7:0]  modem_ff [`MODEM_WORDS];
  logic [11:0] tone_ff  [`TONE_WORDS];
  logic [11:0] sub_ff   [`SUB_WORDS];
  logic [13:0] gain_ff  [`GAIN_WORDS];
  logic        seed1Zero_ff;
  logic        seed2Zero_ff;

  // Reset value of a modem word; only sync patterns have non-zero defaults
  function automatic logic [7:0] modemDefault(input int i);
    logic [15:0] pair;
    case (i / 2)
      0:       pair = `FRAME_SYNC_RESET;
      3:       pair = `BIT_SYNC_RESET;
      default: pair = `SEED_RESET;
    endcase
    return (i % 2 == 0) ? pair[7:0] : pair[15:8];
  endfunction

  // A seed of all zeros disables scrambling after the frame head
  function automatic logic seedIsZero(input logic [7:0] lo, input logic [7:0] hi);
    return {hi, lo} == 16'h0000;
  endfunction

  // Port writes; writes while busy are ignored, so the host must pace itself
  assign wrStrobe = regWrEn && (regAddr == `PROG_PORT_OFFSET)
                    && (state_ff == ST_READY);

  prog_word_decoder u_decoder (
    .clk      (clk),
    .rstn     (rstn),
    .busRst   (busRst),
    .wrStrobe (wrStrobe),
    .wrWord   (regWrData),
    .word     (word.src)
  );

  // Ready/busy pacing of the port
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_ff   <= ST_READY;
      busyCnt_ff <= '0;
    end else if (busRst) begin
      state_ff   <= ST_READY;
      busyCnt_ff <= '0;
    end else begin
      case (state_ff)
        ST_READY: begin
          if (wrStrobe) begin
            state_ff   <= ST_BUSY;
            busyCnt_ff <= CW'(BUSY_CYCLES - 1);
          end
        end
        ST_BUSY: begin
          if (busyCnt_ff == '0) begin
            state_ff <= ST_READY;
          end else begin
            busyCnt_ff <= busyCnt_ff - CW'(1);
          end
        end
        default: begin
          state_ff   <= ST_READY;
          busyCnt_ff <= '0;
        end
      endcase
    end
  end

  // Ready flag output, registered so it drops the edge after the write
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      progReady <= 1'b1;
    end else if (busRst) begin
      progReady <= 1'b1;
    end else if (wrStrobe) begin
      progReady <= 1'b0;
    end else if (state_ff == ST_BUSY && busyCnt_ff == '0) begin
      progReady <= 1'b1;
    end
  end

  // Register reads: the port itself reads as zero, status shows the ready flag
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdData_ff <= 16'h0000;
    end else if (regRdEn) begin
      rdData_ff <= 16'h0000;
      if (regAddr == `STATUS_OFFSET) begin
        rdData_ff[`STATUS_READY_BIT] <= progReady;
      end
    end
  end
  assign regRdData = rdData_ff;

  // Modem block: bytes in the low bits, words stored in index order
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < `MODEM_WORDS; i++) modem_ff[i] <= modemDefault(i);
    end else if (busRst) begin
      for (int i = 0; i < `MODEM_WORDS; i++) modem_ff[i] <= modemDefault(i);
    end else if (word.valid && word.blk == BLK_MODEM && word.idx < 4'(`MODEM_WORDS)) begin
      modem_ff[word.idx[2:0]] <= word.data[7:0];
    end
  end

  // Tone block; untouched words keep their previous values
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < `TONE_WORDS; i++) tone_ff[i] <= `WORD12_RESET;
    end else if (busRst) begin
      for (int i = 0; i < `TONE_WORDS; i++) tone_ff[i] <= `WORD12_RESET;
    end else if (word.valid && word.blk == BLK_TONE && word.idx < 4'(`TONE_WORDS)) begin
      tone_ff[word.idx[2:0]] <= word.data[11:0];
    end
  end

  // Sub-audio block
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < `SUB_WORDS; i++) sub_ff[i] <= `WORD12_RESET;
    end else if (busRst) begin
      for (int i = 0; i < `SUB_WORDS; i++) sub_ff[i] <= `WORD12_RESET;
    end else if (word.valid && word.blk == BLK_SUB && word.idx < 4'(`SUB_WORDS)) begin
      sub_ff[word.idx[2:0]] <= word.data[11:0];
    end
  end

  // Gain and offset block, 14-bit words; the last one is the production test word
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < `GAIN_WORDS; i++) gain_ff[i] <= `WORD14_RESET;
    end else if (busRst) begin
      for (int i = 0; i < `GAIN_WORDS; i++) gain_ff[i] <= `WORD14_RESET;
    end else if (word.valid && word.blk == BLK_GAIN && word.idx < 4'(`GAIN_WORDS)) begin
      gain_ff[word.idx] <= word.data;
    end
  end

  // Zero-seed flags kept as flops so downstream sees clean levels
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      seed1Zero_ff <= 1'b1;
      seed2Zero_ff <= 1'b1;
    end else begin
      seed1Zero_ff <= seedIsZero(modem_ff[2], modem_ff[3]);
      seed2Zero_ff <= seedIsZero(modem_ff[4], modem_ff[5]);
    end
  end

  // Field wiring straight from the stored words; seed bypass comes from the zero-seed flops
  assign frameSync     = {modem_ff[1], modem_ff[0]};
  assign scrambleSeed1 = {modem_ff[3], modem_ff[2]};
  assign scrambleSeed2 = {modem_ff[5], modem_ff[4]};
  assign bitSync       = {modem_ff[7], modem_ff[6]};
  assign seed1Bypass   = seed1Zero_ff;
  assign seed2Bypass   = seed2Zero_ff;

  assign toneTxLevel     = tone_ff[0][11:1];
  assign deemphEn        = tone_ff[0][0];
  assign toneLength      = tone_ff[1][11:10];
  assign detectThreshold = tone_ff[1][9:4];
  assign detectBandwidth = tone_ff[1][3:0];
  assign progTones       = {tone_ff[5][10:0], tone_ff[4][10:0], tone_ff[3][10:0], tone_ff[2][10:0]};

  assign subTxLevel               = sub_ff[0];
  assign long_digital_code_select = sub_ff[1][11];
  assign subDetect                = sub_ff[1][9:0];
  assign digitalCode              = {sub_ff[3], sub_ff[2]};
  assign dropoutTime              = sub_ff[4][11:8];

  // Gain words flattened, word 0 in the low bits
  always_comb begin
    for (int i = 0; i < `GAIN_WORDS; i++) gainWords[i*14 +: 14] = gain_ff[i];
  end
endmodule
`default_nettype wire

/* File: programming_word_loader_chk.sv */
// Port assertions for the programming word loader
`default_nettype none
module programming_word_loader_chk #(
  parameter int BUSY_CYCLES = 4
)(
  input wire logic         clk,
  input wire logic         rstn,
  input wire logic         busRst,
  input wire logic         regWrEn,
  input wire logic         regRdEn,
  input wire logic [7:0]   regAddr,
  input wire logic [15:0]  regWrData,
  input wire logic [15:0]  regRdData,
  input wire logic         progReady,
  input wire logic [15:0]  frameSync,
  input wire logic [15:0]  scrambleSeed1,
  input wire logic         seed1Bypass,
  input wire logic [15:0]  bitSync,
  input wire logic [10:0]  toneTxLevel,
  input wire logic         deemphEn,
  input wire logic [11:0]  subTxLevel,
  input wire logic [125:0] gainWords
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int readyMax = BUSY_CYCLES + 2;
  logic acc;
  // A write counts only when idle and not under bus reset
  assign acc = regWrEn && regAddr == 8'hc8 && progReady && !busRst;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  AST_WR_CLEARS: assert property (acc && regWrData[14:12] != 3'h7 |=> !progReady)
    else $error("Ready flag not cleared by a write");
  AST_READY_BACK: assert property ($fell(progReady) |-> ##[1:readyMax] progReady)
    else $error("Ready flag did not return in time");
  AST_SYNC_LOW: assert property (acc && regWrData[15:12] == 4'hc |-> ##2 frameSync[7:0] == $past(regWrData[7:0], 2))
    else $error("Frame sync low byte not loaded");
  AST_TONE_FIRST: assert property (acc && regWrData[15:12] == 4'hd |-> ##2
    {toneTxLevel, deemphEn} == $past(regWrData[11:0], 2))
    else $error("Tone level word not loaded");
  AST_SUB_FIRST: assert property (acc && regWrData[15:12] == 4'he |-> ##2 subTxLevel == $past(regWrData[11:0], 2))
    else $error("Sub-audio level not loaded");
  AST_GAIN_FIRST: assert property (acc && regWrData[15:14] == 2'b10 |-> ##2 gainWords[13:0] == $past(regWrData[13:0], 2))
    else $error("Gain word not loaded");
  AST_BUS_RESET: assert property (busRst |=> frameSync == 16'hcb23 && bitSync == 16'h5555 && progReady)
    else $error("Bus reset did not restore defaults");
  AST_SEED_BYPASS: assert property ($changed(scrambleSeed1) |=> seed1Bypass == (scrambleSeed1 == 16'h0000))
    else $error("Seed bypass does not follow the seed");
  AST_PORT_READS_ZERO: assert property (regRdEn && regAddr == 8'hc8 |=> regRdData == 16'h0000)
    else $error("Programming port read not zero");
  cover property (acc);
  cover property (busRst);
  cover property ($rose(progReady));
endmodule

bind programming_word_loader programming_word_loader_chk #(.BUSY_CYCLES(BUSY_CYCLES)) programming_word_loader_chk_i (
  .clk, .rstn, .busRst, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData, .progReady, .frameSync,
  .scrambleSeed1, .seed1Bypass, .bitSync, .toneTxLevel, .deemphEn, .subTxLevel, .gainWords);
`default_nettype wire

/* File: host_model.sv */
// Host model that writes and reads the loader registers
`default_nettype none
module host_model (
  input  wire logic        clk,
  input  wire logic        progReady,
  input  wire logic [15:0] regRdData,
  output logic             regWrEn,
  output logic             regRdEn,
  output logic      [7:0]  regAddr,
  output logic      [15:0] regWrData
);
  timeunit 1ns;
  timeprecision 1ps;
  // Power-down bits 5 and 4 set, bit 3 clear before any programming
  localparam logic [7:0] pwrDownCfg = 8'h30;
  // Receive and transmit kept off while programming
  localparam logic [1:0] modeCfg = 2'h0;
  initial begin
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 8'h00;
    regWrData = 16'h0000;
  end
  // Bounded poll so a stuck flag cannot hang the host
  task automatic waitReady();
    for (int i = 0; i < 64 && progReady !== 1'b1; i++) @(posedge clk);
    #1;
  endtask
  // Skipping the wait is only for tests of a write while busy
  task automatic writeWord(input logic [15:0] w, input bit waitRdy);
    if (waitRdy) waitReady();
    regAddr = 8'hc8;
    regWrData = w;
    regWrEn = 1'b1;
    @(posedge clk);
    #1;
    regWrEn = 1'b0;
    regAddr = ~regAddr;
    regWrData = ~regWrData;
    @(posedge clk);
    #1;
  endtask
  // Read data is registered on the request edge
  task automatic readReg(input logic [7:0] a, output logic [15:0] d);
    regAddr = a;
    regRdEn = 1'b1;
    @(posedge clk);
    #1;
    regRdEn = 1'b0;
    regAddr = ~a;
    d = regRdData;
  endtask
endmodule
`default_nettype wire

/* File: tb_programming_word_loader.sv */
// Self-checking bench for the programming word loader
`default_nettype none
module tb_programming_word_loader;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int busyCycles = 4;
  logic         clk = 1'b0, rstn = 1'b0, busRst = 1'b0, regWrEn, regRdEn, progReady;
  logic         seed1Bypass, seed2Bypass, deemphEn, long_digital_code_select;
  logic [7:0]   regAddr, modemBytes [8];
  logic [15:0]  regWrData, regRdData, frameSync, scrambleSeed1, scrambleSeed2, bitSync, rd, subWords [5];
  logic [10:0]  toneTxLevel;
  logic [1:0]   toneLength;
  logic [5:0]   detectThreshold;
  logic [3:0]   detectBandwidth, dropoutTime;
  logic [43:0]  progTones;
  logic [11:0]  subTxLevel;
  logic [9:0]   subDetect;
  logic [23:0]  digitalCode;
  logic [125:0] gainWords;
  int           fails = 0, samples_checked = 0, n;
  always #12.5 clk = ~clk;
  programming_word_loader #(.BUSY_CYCLES(busyCycles)) programming_word_loader_i (
    .clk, .rstn, .busRst, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData, .progReady, .frameSync,
    .scrambleSeed1, .scrambleSeed2, .seed1Bypass, .seed2Bypass, .bitSync, .toneTxLevel, .deemphEn,
    .toneLength, .detectThreshold, .detectBandwidth, .progTones, .subTxLevel, .long_digital_code_select,
    .subDetect, .digitalCode, .dropoutTime, .gainWords);
  host_model host_model_i (.clk, .progReady, .regRdData, .regWrEn, .regRdEn, .regAddr, .regWrData);
  task automatic chk(input logic [125:0] got, input logic [125:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] w);
    host_model_i.writeWord(w, 1'b1);
  endtask
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Main sequence: whole, partial and restarted blocks, busy writes, bus reset
  initial begin
    modemBytes = '{8'h12, 8'h34, 8'h56, 8'h78, 8'h00, 8'h00, 8'h9a, 8'hbc};
    subWords = '{16'he123, 16'h6a55, 16'h6abc, 16'h60de, 16'h6700};
    repeat (16) @(posedge clk);
    #1;
    rstn = 1'b1;
    chk({frameSync, bitSync, scrambleSeed1, seed1Bypass, progReady}, {16'hcb23, 16'h5555, 16'h0, 2'b11});
    foreach (modemBytes[i]) wr({i == 0, 7'h40, modemBytes[i]});
    host_model_i.waitReady();
    chk({frameSync, scrambleSeed1, scrambleSeed2, bitSync}, {16'h3412, 16'h7856, 16'h0, 16'hbc9a});
    chk({seed1Bypass, seed2Bypass}, 2'b01);
    wr(16'hdb4b);
    wr(16'h5aa9);
    host_model_i.waitReady();
    chk({toneTxLevel, deemphEn, toneLength, detectThreshold, detectBandwidth, progTones},
        {11'h5a5, 1'b1, 2'h2, 6'h2a, 4'h9, 44'h0});
    foreach (subWords[i]) wr(subWords[i]);
    host_model_i.waitReady();
    chk({subTxLevel, long_digital_code_select, subDetect, digitalCode, dropoutTime},
        {12'h123, 1'b1, 10'h255, 24'h0deabc, 4'h7});
    wr(16'h9234);
    chk(progReady, 1'b0);
    // A write while busy must be dropped, not queued
    host_model_i.writeWord(16'h0555, 1'b0);
    for (n = 0; n < 20 && progReady !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    chk(n >= 1 && n <= busyCycles, 1'b1);
    wr(16'h0123);
    wr(16'h3fff);
    host_model_i.waitReady();
    chk(gainWords[41:0], {14'h3fff, 14'h0123, 14'h1234});
    host_model_i.readReg(8'hc8, rd);
    chk(rd, 16'h0000);
    host_model_i.readReg(8'hc6, rd);
    chk(rd, 16'h0001);
    wr(16'hc0ff);
    wr(16'h4011);
    host_model_i.waitReady();
    chk(frameSync, 16'h11ff);
    busRst = 1'b1;
    @(posedge clk);
    #1;
    busRst = 1'b0;
    @(posedge clk);
    #1;
    chk({frameSync, bitSync, subTxLevel, gainWords[13:0], seed1Bypass}, {16'hcb23, 16'h5555, 26'h0, 1'b1});
    summarize();
  end
  // Run takes well under ten microseconds; this span is ample
  initial begin
    #50us;
    fails++;
    summarize();
  end
endmodule
`default_nettype wire
